// *** cemc_top.sv ***
// Module: error marking and error action control of the memory subsystem
`timescale 1ns/1ps
// Functional notes
// RULE1 - Start marking only on an uncorrected error not yet marked.
// RULE2 - Replace only the erroneous doubleword and its ECC, nothing around it.
// RULE3 - Interrupt packet data is stored unmarked into eight data registers and ECC.
// RULE4 - Mark level-1 data, level-2 data, incoming and outgoing cacheable bus data.
// RULE5 - Cacheable data carries single-correct double-detect ECC per doubleword.
// RULE6 - Source tag register: 14 writable bits, upper bits read zero.
// RULE7 - Power-on reset sets relaxed detection, clears all else.
// RULE8 - Other resets log handler and relaxed bits, then clear control.
// RULE9 - Bit 9 gates traps from uncorrected and raw uncorrected errors.
// RULE10 - Bit 8 gates traps from corrected errors and degradation events.
// RULE11 - Control register steers detection masking, trap masking, multiple-fault trap.
// RULE12 - Marker holds tag at 55:42 and 13:0, zeros, three-bit error ECC.
// RULE13 - Syndrome 7f means already marked; other multibit syndromes are raw.
// RULE14 - Relaxed detection suppresses urgent and access errors when work can continue.
// RULE15 - Handler bit set on async fault trap, cleared on trap return.
// RULE16 - Already marked data passes unchanged and is not reported again.
module cemc_top
    import cemc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        other_reset_in,
    // Register access
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_asi_in,
    input  wire logic [63:0] reg_va_in,
    input  wire logic [63:0] reg_wdata_in,
    output logic [63:0]      reg_rdata_out,
    output logic             reg_rvalid_out,
    // Cacheable data paths
    input  wire cemc_chan_s  chan_in [CEMC_NUM_SRC],
    output logic             chan_valid_out [CEMC_NUM_SRC],
    output cemc_dw_s         chan_dw_out [CEMC_NUM_SRC],
    output logic             chan_raw_ue_out [CEMC_NUM_SRC],
    // Interrupt packet receive
    input  wire logic        int_wr_in,
    input  wire logic [2:0]  int_idx_in,
    input  wire cemc_dw_s    int_dw_in,
    input  wire logic [2:0]  int_rd_idx_in,
    output logic [63:0]      int_rdata_out,
    output logic [63:0]      int_recc_out,
    // Error events and traps
    input  wire logic        ue_event_in,
    input  wire logic        cedg_event_in,
    input  wire logic        urgent_err_in,
    input  wire logic        can_continue_in,
    input  wire logic        async_trap_taken_in,
    input  wire logic        trap_return_in,
    output logic             ue_trap_out,
    output logic             cedg_trap_out,
    output logic             urgent_detect_out,
    output logic             multi_fault_trap_out,
    // State change log capture
    output logic             log_valid_out,
    output logic             log_relaxed_out,
    output logic             log_handler_out,
    // Control state
    output logic             relaxed_detection_out,
    output logic             urgent_handler_active_out
);

    // ****************************************
    // Registers
    // ****************************************
    logic [13:0] marker_source_tag_reg;
    logic        trap_mask_uncorrected_reg;
    logic        trap_mask_corrected_degraded_reg;
    logic        relaxed_detection_reg;
    logic        urgent_handler_active_reg;
    logic [63:0] int_data_reg [CEMC_INT_WORDS];
    logic [7:0]  int_ecc_reg  [CEMC_INT_WORDS];
    logic        hit_tag;
    logic        hit_ctl;
    logic        urgent_seen;

    function automatic logic reg_hit(input logic [7:0] asi, input logic [63:0] va,
                                     input logic [7:0] want_asi, input logic [63:0] want_va);
        reg_hit = (asi == want_asi) && (va == want_va);
    endfunction

    assign hit_tag = reg_hit(reg_asi_in, reg_va_in, CEMC_ASI_TAG, CEMC_VA_TAG);
    assign hit_ctl = reg_hit(reg_asi_in, reg_va_in, CEMC_ASI_CTL, CEMC_VA_CTL);

    // ****************************************
    // Source tag register
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            marker_source_tag_reg <= CEMC_TAG_RESET;
        else if (reg_wr_in && hit_tag)
            marker_source_tag_reg <= reg_wdata_in[CEMC_TAG_W-1:0]; // RULE6
    end

    // ****************************************
    // Error action control register
    // ****************************************
    // A pending hardware event wins over a software write in the same cycle
    assign urgent_seen = urgent_err_in && !(relaxed_detection_reg && can_continue_in); // RULE14

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            trap_mask_uncorrected_reg        <= CEMC_POR_OTHER; // RULE7
            trap_mask_corrected_degraded_reg <= CEMC_POR_OTHER;
            relaxed_detection_reg            <= CEMC_POR_RELAXED; // RULE7
            urgent_handler_active_reg        <= CEMC_POR_OTHER;
        end
        else if (other_reset_in)
        begin
            trap_mask_uncorrected_reg        <= CEMC_SOFT_CLEAR; // RULE8
            trap_mask_corrected_degraded_reg <= CEMC_SOFT_CLEAR;
            relaxed_detection_reg            <= CEMC_SOFT_CLEAR;
            urgent_handler_active_reg        <= CEMC_SOFT_CLEAR;
        end
        else
        begin
            if (reg_wr_in && hit_ctl)
            begin
                trap_mask_uncorrected_reg        <= reg_wdata_in[CEMC_BIT_TRAP_UE]; // RULE9
                trap_mask_corrected_degraded_reg <= reg_wdata_in[CEMC_BIT_TRAP_CEDG]; // RULE10
            end
            if (urgent_seen && urgent_handler_active_reg)
                relaxed_detection_reg <= 1'b1; // RULE11
            else if (reg_wr_in && hit_ctl)
                relaxed_detection_reg <= reg_wdata_in[CEMC_BIT_RELAXED];
            if (async_trap_taken_in)
                urgent_handler_active_reg <= 1'b1; // RULE15
            else if (trap_return_in)
                urgent_handler_active_reg <= 1'b0; // RULE15
            else if (reg_wr_in && hit_ctl)
                urgent_handler_active_reg <= reg_wdata_in[CEMC_BIT_HANDLER];
        end
    end

    // ****************************************
    // State change log capture
    // ****************************************
    // Copy taken from the values held before the clear lands
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            log_valid_out   <= 1'b0;
            log_relaxed_out <= 1'b0;
            log_handler_out <= 1'b0;
        end
        else
        begin
            log_valid_out <= other_reset_in; // RULE8
            if (other_reset_in)
            begin
                log_relaxed_out <= relaxed_detection_reg; // RULE8
                log_handler_out <= urgent_handler_active_reg;
            end
        end
    end

    // ****************************************
    // Trap and detection gating
    // ****************************************
    assign ue_trap_out               = ue_event_in && trap_mask_uncorrected_reg; // RULE9 RULE11
    assign cedg_trap_out             = cedg_event_in && trap_mask_corrected_degraded_reg; // RULE10 RULE11
    assign urgent_detect_out         = urgent_seen; // RULE14 RULE11
    assign multi_fault_trap_out      = urgent_seen && urgent_handler_active_reg; // RULE11
    assign relaxed_detection_out     = relaxed_detection_reg;
    assign urgent_handler_active_out = urgent_handler_active_reg;

    // ****************************************
    // Register read
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            reg_rdata_out  <= '0;
            if (reg_rd_in && hit_tag)
                reg_rdata_out[CEMC_TAG_W-1:0] <= marker_source_tag_reg; // RULE6
            else if (reg_rd_in && hit_ctl)
            begin
                reg_rdata_out[CEMC_BIT_TRAP_UE]   <= trap_mask_uncorrected_reg;
                reg_rdata_out[CEMC_BIT_TRAP_CEDG] <= trap_mask_corrected_degraded_reg;
                reg_rdata_out[CEMC_BIT_RELAXED]   <= relaxed_detection_reg;
                reg_rdata_out[CEMC_BIT_HANDLER]   <= urgent_handler_active_reg;
            end
        end
    end

    // ****************************************
    // Cacheable data marking
    // ****************************************
    // Incoming bus data is tagged as memory system, the rest as this core
    for (genvar i = 0; i < CEMC_NUM_SRC; i++)
    begin : g_mark
        cemc_marker u_marker (
            .sys_clk_in (sys_clk_in),
            .rstn_in    (rstn_in),
            .chan_in    (chan_in[i]),
            .tag_in     ((i == CEMC_SRC_BUS_IN) ? CEMC_BUS_IN_TAG : marker_source_tag_reg), // RULE4
            .valid_out  (chan_valid_out[i]),
            .dw_out     (chan_dw_out[i]),
            .raw_ue_out (chan_raw_ue_out[i])
        );
    end

    // ****************************************
    // Interrupt receive registers
    // ****************************************
    // Never marked: a bad word is simply overwritten by the next packet
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            for (int k = 0; k < CEMC_INT_WORDS; k++)
            begin
                int_data_reg[k] <= '0;
                int_ecc_reg[k]  <= '0;
            end
        end
        else if (int_wr_in)
        begin
            int_data_reg[int_idx_in] <= int_dw_in.data; // RULE3
            int_ecc_reg[int_idx_in]  <= int_dw_in.ecc; // RULE3
        end
    end

    always_comb
    begin
        int_rdata_out = int_data_reg[int_rd_idx_in];
        int_recc_out  = '0;
        for (int k = 0; k < CEMC_INT_WORDS; k++)
            int_recc_out[k*8 +: 8] = int_ecc_reg[k];
    end

    // ****************************************
    // Checks
    // ****************************************
    a_int_unmarked: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        int_wr_in ##1 (int_rd_idx_in == $past(int_idx_in)) |-> int_rdata_out == $past(int_dw_in.data))
        else $error("Interrupt data altered"); // RULE3
    a_tag_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_rd_in && hit_tag |=> reg_rdata_out[63:14] == '0 && reg_rdata_out[13:0] == $past(marker_source_tag_reg))
        else $error("Tag read wrong"); // RULE6
    a_other_reset_clear: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        other_reset_in |=> !relaxed_detection_reg && !urgent_handler_active_reg && !trap_mask_uncorrected_reg
        && log_valid_out && log_relaxed_out == $past(relaxed_detection_reg)) else $error("Other reset wrong"); // RULE8
    a_ue_trap_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_wr_in && hit_ctl && !other_reset_in ##1 ue_event_in
        |-> ue_trap_out == $past(reg_wdata_in[CEMC_BIT_TRAP_UE])) else $error("Uncorrected trap ungated"); // RULE9
    a_cedg_trap_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_wr_in && hit_ctl && !other_reset_in ##1 cedg_event_in
        |-> cedg_trap_out == $past(reg_wdata_in[CEMC_BIT_TRAP_CEDG])) else $error("Corrected trap ungated"); // RULE10
    a_relaxed_suppress: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        urgent_err_in && relaxed_detection_reg && can_continue_in |-> !urgent_detect_out)
        else $error("Relaxed detection ignored"); // RULE14
    a_handler_set: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        async_trap_taken_in && !other_reset_in |=> urgent_handler_active_reg) else $error("Handler not set"); // RULE15
    a_handler_clear: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        trap_return_in && !async_trap_taken_in |=> !urgent_handler_active_reg) else $error("Handler not cleared"); // RULE15

endmodule

// *** cemc_pkg.sv ***
// Package: constants and types for the cache error marking control block
package cemc_pkg;

    // ****************************************
    // Register access codes and offsets
    // ****************************************
    localparam logic [7:0]  CEMC_ASI_TAG          = 8'h6e;
    localparam logic [7:0]  CEMC_ASI_CTL          = 8'h4c;
    localparam logic [63:0] CEMC_VA_TAG           = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CEMC_VA_CTL           = 64'h0000_0000_0000_0010;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          CEMC_TAG_W            = 14;
    localparam int          CEMC_BIT_TRAP_UE      = 9;
    localparam int          CEMC_BIT_TRAP_CEDG    = 8;
    localparam int          CEMC_BIT_RELAXED      = 1;
    localparam int          CEMC_BIT_HANDLER      = 0;
    localparam logic        CEMC_POR_RELAXED      = 1'b1;
    localparam logic        CEMC_POR_OTHER        = 1'b0;
    localparam logic        CEMC_SOFT_CLEAR       = 1'b0;
    localparam logic [13:0] CEMC_TAG_RESET        = 14'h0000;
    localparam logic [13:0] CEMC_BUS_IN_TAG       = 14'h0000;

    // ****************************************
    // Marker layout
    // ****************************************
    localparam logic [7:0]  CEMC_SYN_MARKED       = 8'h7f;
    localparam int          CEMC_TAG_HI_LSB       = 42;
    localparam int          CEMC_TAG_LO_LSB       = 0;
    localparam int          CEMC_ERR_BIT_A        = 63;
    localparam int          CEMC_ERR_BIT_B        = 35;
    localparam int          CEMC_ERR_BIT_C        = 22;
    localparam logic [7:0]  CEMC_MARK_ECC_DEFAULT = 8'h00;

    // ****************************************
    // Data path sources
    // ****************************************
    localparam int          CEMC_NUM_SRC          = 4;
    localparam int          CEMC_SRC_L1           = 0;
    localparam int          CEMC_SRC_L2           = 1;
    localparam int          CEMC_SRC_BUS_IN       = 2;
    localparam int          CEMC_SRC_BUS_OUT      = 3;
    localparam int          CEMC_INT_WORDS        = 8;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  ecc;
    } cemc_dw_s;

    typedef struct packed {
        logic        valid;
        cemc_dw_s    dw;
        logic [7:0]  syn;
        logic        ue;
    } cemc_chan_s;

endpackage

// *** cemc_marker.sv ***
// Module: doubleword error marker for one cacheable data path
`timescale 1ns/1ps
module cemc_marker
    import cemc_pkg::*;
#(
    parameter logic [7:0] MARK_ECC = CEMC_MARK_ECC_DEFAULT
)
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    // Incoming doubleword with checker result
    input  wire cemc_chan_s  chan_in,
    input  wire logic [13:0] tag_in,
    // Outgoing doubleword
    output logic             valid_out,
    output cemc_dw_s         dw_out,
    output logic             raw_ue_out
);

    // ****************************************
    // Classification
    // ****************************************
    logic     is_raw;
    cemc_dw_s mark_dw;

    assign is_raw = chan_in.valid && chan_in.ue && (chan_in.syn != CEMC_SYN_MARKED); // RULE1 RULE13

    // Error bits forced to zero; the stored ECC makes them the three-bit error
    always_comb
    begin
        mark_dw      = '0;
        mark_dw.data[CEMC_TAG_HI_LSB +: CEMC_TAG_W] = tag_in; // RULE12
        mark_dw.data[CEMC_TAG_LO_LSB +: CEMC_TAG_W] = tag_in; // RULE12
        mark_dw.ecc  = MARK_ECC; // RULE12
    end

    // ****************************************
    // Output stage
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            valid_out  <= 1'b0;
            dw_out     <= '0;
            raw_ue_out <= 1'b0;
        end
        else
        begin
            valid_out  <= chan_in.valid;
            // Only this doubleword is replaced, neighbours go through as sent
            dw_out     <= is_raw ? mark_dw : chan_in.dw; // RULE2 RULE16 RULE5
            raw_ue_out <= is_raw; // RULE16
        end
    end

    a_marked_passes: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        chan_in.valid && chan_in.ue && chan_in.syn == CEMC_SYN_MARKED
        |=> dw_out == $past(chan_in.dw) && !raw_ue_out) else $error("Marked data altered"); // RULE16
    a_raw_tag_placed: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        is_raw |=> raw_ue_out && dw_out.data[55:42] == $past(tag_in)
        && dw_out.data[13:0] == $past(tag_in) && dw_out.data[41:14] == '0) else $error("Marker layout wrong"); // RULE12
    a_clean_passes: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        chan_in.valid && !chan_in.ue |=> dw_out == $past(chan_in.dw)) else $error("Clean data altered"); // RULE2

endmodule

// *** cemc_bus_model.sv ***
// System bus partner: feeds incoming cacheable words and interrupt packets, watches outgoing words
`timescale 1ns/1ps
module cemc_bus_model
    import cemc_pkg::*;
(
    // Clock
    input  wire logic     sys_clk_in,
    // Incoming cacheable word
    output cemc_chan_s    line_out,
    // Interrupt packet word
    output logic          int_wr_out,
    output logic [2:0]    int_idx_out,
    output cemc_dw_s      int_dw_out,
    // Outgoing cacheable word from the device
    input  wire logic     out_valid_in,
    input  wire cemc_dw_s out_dw_in
);
    cemc_dw_s seen_dw;

    initial
    begin
        line_out    = '0;
        int_wr_out  = 1'b0;
        int_idx_out = 3'h0;
        int_dw_out  = '0;
    end

    always @(posedge sys_clk_in)
        if (out_valid_in)
            seen_dw <= out_dw_in;

    // Released lines carry inverted data so a stale word never passes for a fresh one
    task automatic send_line(input cemc_dw_s dw, input logic [7:0] syn, input logic ue);
        @(negedge sys_clk_in);
        line_out = '{1'b1, dw, syn, ue};
        @(negedge sys_clk_in);
        line_out = '{1'b0, ~dw, ~syn, 1'b0};
    endtask

    task automatic send_int(input logic [2:0] idx, input cemc_dw_s dw);
        @(negedge sys_clk_in);
        int_wr_out  = 1'b1;
        int_idx_out = idx;
        int_dw_out  = dw;
        @(negedge sys_clk_in);
        int_wr_out  = 1'b0;
        int_idx_out = ~idx;
        int_dw_out  = ~dw;
    endtask
endmodule

// *** cemc_top_test.sv ***
// Testbench: register, trap, marking and interrupt store checks of the marking control block
`timescale 1ns/1ps
module cemc_top_test
    import cemc_pkg::*;
;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, other_reset_in = 1'b0, reg_rd_in = 1'b0, reg_wr_in = 1'b0;
    logic [7:0] reg_asi_in = 8'h00;
    logic [63:0] reg_va_in = 64'h0, reg_wdata_in = 64'h0, reg_rdata_out, int_rdata_out, int_recc_out, rd;
    logic reg_rvalid_out, int_wr, ue_trap_out, cedg_trap_out, urgent_detect_out, multi_fault_trap_out;
    logic ue_event_in = 1'b0, cedg_event_in = 1'b0, urgent_err_in = 1'b0, can_continue_in = 1'b0;
    logic async_trap_taken_in = 1'b0, trap_return_in = 1'b0, log_valid_out, log_relaxed_out, log_handler_out;
    logic relaxed_detection_out, urgent_handler_active_out, raw;
    logic [2:0] int_idx, int_rd_idx_in = 3'h0;
    cemc_dw_s int_dw;
    cemc_chan_s tb_chan [CEMC_NUM_SRC], chan_mux [CEMC_NUM_SRC], bus_line;
    logic chan_valid_out [CEMC_NUM_SRC], chan_raw_ue_out [CEMC_NUM_SRC];
    cemc_dw_s chan_dw_out [CEMC_NUM_SRC];
    int err_count = 0, total_checks = 0, cycles = 0;
    localparam logic [13:0] TAG = 14'h2abc;

    always #20 sys_clk_in = ~sys_clk_in;
    // Index two belongs to the bus partner, the rest to the bench
    always_comb
        for (int i = 0; i < CEMC_NUM_SRC; i++)
            chan_mux[i] = (i == CEMC_SRC_BUS_IN) ? bus_line : tb_chan[i];
    initial
        for (int i = 0; i < CEMC_NUM_SRC; i++)
            tb_chan[i] = '0;

    cemc_top u_cemc_top (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .other_reset_in(other_reset_in),
        .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_asi_in(reg_asi_in), .reg_va_in(reg_va_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .chan_in(chan_mux), .chan_valid_out(chan_valid_out), .chan_dw_out(chan_dw_out),
        .chan_raw_ue_out(chan_raw_ue_out), .int_wr_in(int_wr), .int_idx_in(int_idx), .int_dw_in(int_dw),
        .int_rd_idx_in(int_rd_idx_in), .int_rdata_out(int_rdata_out), .int_recc_out(int_recc_out),
        .ue_event_in(ue_event_in), .cedg_event_in(cedg_event_in), .urgent_err_in(urgent_err_in),
        .can_continue_in(can_continue_in), .async_trap_taken_in(async_trap_taken_in),
        .trap_return_in(trap_return_in), .ue_trap_out(ue_trap_out), .cedg_trap_out(cedg_trap_out),
        .urgent_detect_out(urgent_detect_out), .multi_fault_trap_out(multi_fault_trap_out),
        .log_valid_out(log_valid_out), .log_relaxed_out(log_relaxed_out), .log_handler_out(log_handler_out),
        .relaxed_detection_out(relaxed_detection_out), .urgent_handler_active_out(urgent_handler_active_out));

    cemc_bus_model u_cemc_bus_model (.sys_clk_in(sys_clk_in), .line_out(bus_line), .int_wr_out(int_wr),
        .int_idx_out(int_idx), .int_dw_out(int_dw), .out_valid_in(chan_valid_out[CEMC_SRC_BUS_OUT]),
        .out_dw_in(chan_dw_out[CEMC_SRC_BUS_OUT]));

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk64(what, {63'h0, exp}, {63'h0, got});
    endtask

    task automatic reg_write(input logic [7:0] asi, input logic [63:0] va, input logic [63:0] d);
        @(negedge sys_clk_in);
        {reg_wr_in, reg_asi_in, reg_va_in, reg_wdata_in} = {1'b1, asi, va, d};
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
    endtask

    // Read data is taken one cycle after the strobe, the only cycle it stands
    task automatic reg_read(input logic [7:0] asi, input logic [63:0] va, output logic [63:0] d);
        @(negedge sys_clk_in);
        {reg_rd_in, reg_asi_in, reg_va_in} = {1'b1, asi, va};
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        chk1("rvalid", 1'b1, reg_rvalid_out);
        d = reg_rdata_out;
    endtask

    task automatic pulse(ref logic s);
        @(negedge sys_clk_in);
        s = 1'b1;
        @(negedge sys_clk_in);
        s = 1'b0;
    endtask

    function automatic logic [63:0] mark(input logic [13:0] t);
        mark = 64'h0;
        mark[CEMC_TAG_HI_LSB +: CEMC_TAG_W] = t;
        mark[CEMC_TAG_LO_LSB +: CEMC_TAG_W] = t;
    endfunction

    // Pass 0 and 1 swap raw and marked words between paths; pass 2 is clean data
    task automatic path_pass(input int p);
        fork
            u_cemc_bus_model.send_line('{64'h0123_4567_89ab_cd02, 8'h5a}, (p % 2) ? CEMC_SYN_MARKED : 8'h33, p < 2);
            begin
                @(negedge sys_clk_in);
                for (int i = 0; i < CEMC_NUM_SRC; i++)
                    tb_chan[i] = '{1'b1, '{64'h0123_4567_89ab_cd00 + i, 8'h5a},
                                   ((i + p) % 2) ? CEMC_SYN_MARKED : 8'h33, p < 2};
                @(negedge sys_clk_in);
                for (int i = 0; i < CEMC_NUM_SRC; i++)
                    tb_chan[i] = '{1'b0, ~tb_chan[i].dw, ~tb_chan[i].syn, 1'b0};
            end
        join
        for (int i = 0; i < CEMC_NUM_SRC; i++)
        begin
            raw = (p < 2) && ((i + p) % 2 == 0);
            chk1("chan_valid", 1'b1, chan_valid_out[i]);
            chk1("chan_raw_ue", raw, chan_raw_ue_out[i]);
            chk64("chan_data", raw ? mark(i == CEMC_SRC_BUS_IN ? CEMC_BUS_IN_TAG : TAG)
                  : 64'h0123_4567_89ab_cd00 + i, chan_dw_out[i].data);
            chk64("chan_ecc", raw ? CEMC_MARK_ECC_DEFAULT : 8'h5a, chan_dw_out[i].ecc);
        end
    endtask

    always @(posedge sys_clk_in)
    begin
        cycles++;
        // Whole sequence needs under a hundred cycles
        if (cycles == 4000)
        begin
            err_count++;
            summarize();
        end
    end

    initial
    begin
        repeat (12) @(negedge sys_clk_in);
        rstn_in = 1'b1;
        chk1("relaxed", 1'b1, relaxed_detection_out);
        reg_read(CEMC_ASI_CTL, CEMC_VA_CTL, rd);
        chk64("ctl_por", 64'h2, rd);
        reg_write(CEMC_ASI_TAG, CEMC_VA_TAG, 64'hffff_0000_0000_2abc);
        reg_read(CEMC_ASI_TAG, CEMC_VA_TAG, rd);
        chk64("tag", {50'h0, TAG}, rd);
        reg_read(CEMC_ASI_CTL, 64'h18, rd);
        chk64("unmapped", 64'h0, rd);
        reg_write(CEMC_ASI_CTL, CEMC_VA_CTL, 64'hffff_ffff_ffff_ffff);
        reg_read(CEMC_ASI_CTL, CEMC_VA_CTL, rd);
        chk64("ctl_rw", 64'h303, rd);
        {ue_event_in, cedg_event_in} = 2'b11;
        for (int k = 0; k < 2; k++)
        begin
            reg_write(CEMC_ASI_CTL, CEMC_VA_CTL, k ? 64'h100 : 64'h200);
            #1 chk1("ue_trap", k == 0, ue_trap_out);
            chk1("cedg_trap", k == 1, cedg_trap_out);
        end
        urgent_err_in = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            reg_write(CEMC_ASI_CTL, CEMC_VA_CTL, k ? 64'h2 : 64'h0);
            can_continue_in = (k < 2);
            #1 chk1("urgent_detect", k != 1, urgent_detect_out);
        end
        urgent_err_in = 1'b0;
        reg_write(CEMC_ASI_CTL, CEMC_VA_CTL, 64'h0);
        pulse(async_trap_taken_in);
        chk1("handler_set", 1'b1, urgent_handler_active_out);
        {urgent_err_in, can_continue_in} = 2'b10;
        #1 chk1("multi_fault", 1'b1, multi_fault_trap_out);
        @(negedge sys_clk_in);
        urgent_err_in = 1'b0;
        chk1("relaxed_by_hw", 1'b1, relaxed_detection_out);
        pulse(trap_return_in);
        chk1("handler_clear", 1'b0, urgent_handler_active_out);
        pulse(async_trap_taken_in);
        pulse(other_reset_in);
        chk1("log_valid", 1'b1, log_valid_out);
        chk64("log_bits", 64'h3, {62'h0, log_relaxed_out, log_handler_out});
        reg_read(CEMC_ASI_CTL, CEMC_VA_CTL, rd);
        chk64("ctl_other", 64'h0, rd);
        reg_read(CEMC_ASI_TAG, CEMC_VA_TAG, rd);
        chk64("tag_kept", {50'h0, TAG}, rd);
        for (int p = 0; p < 3; p++)
            path_pass(p);
        // The partner latches the outgoing word at the next rising edge
        @(negedge sys_clk_in);
        chk64("bus_seen", 64'h0123_4567_89ab_cd03, u_cemc_bus_model.seen_dw.data);
        for (int k = 0; k < CEMC_INT_WORDS; k++)
            u_cemc_bus_model.send_int(k[2:0], '{64'hfeed_0000_0000_0000 + k, 8'h10 + k[7:0]});
        for (int k = 0; k < CEMC_INT_WORDS; k++)
        begin
            @(negedge sys_clk_in);
            int_rd_idx_in = k[2:0];
            #1 chk64("int_data", 64'hfeed_0000_0000_0000 + k, int_rdata_out);
            chk64("int_ecc", 8'h10 + k, int_recc_out[8 * k +: 8]);
        end
        @(negedge sys_clk_in);
        rstn_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rstn_in = 1'b1;
        reg_read(CEMC_ASI_CTL, CEMC_VA_CTL, rd);
        chk64("ctl_por2", 64'h2, rd);
        reg_read(CEMC_ASI_TAG, CEMC_VA_TAG, rd);
        chk64("tag_por", {50'h0, CEMC_TAG_RESET}, rd);
        summarize();
    end
endmodule
